// ===== verilog/sltcr_pkg.sv
/*
 * Constants for the serial link transmit control register bank:
 * register offsets, field positions, reset values and encodings.
 * Assumes an 8-bit register port addressed by a 10-bit offset.
 */
package sltcr_pkg;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] A_LINK_EN = 10'h200;
    localparam logic [ADDR_W-1:0] A_MODE    = 10'h201;
    localparam logic [ADDR_W-1:0] A_KM1     = 10'h202;
    localparam logic [ADDR_W-1:0] A_SWSYNC  = 10'h203;
    localparam logic [ADDR_W-1:0] A_CTRL    = 10'h204;
    localparam logic [ADDR_W-1:0] A_TEST    = 10'h205;
    localparam logic [ADDR_W-1:0] A_DID     = 10'h206;
    localparam logic [ADDR_W-1:0] A_COMMA   = 10'h207;
    localparam logic [ADDR_W-1:0] A_STATUS  = 10'h208;
    localparam logic [ADDR_W-1:0] A_PD      = 10'h209;
    localparam logic [ADDR_W-1:0] A_EXTRA_A = 10'h20A;

    // field positions
    localparam int unsigned CTL_SCR_BIT  = 0;
    localparam int unsigned CTL_SFMT_BIT = 1;
    localparam int unsigned CTL_SEL_LSB  = 2;
    localparam int unsigned ST_PLL_BIT   = 2;
    localparam int unsigned ST_ALIGN_BIT = 3;
    localparam int unsigned ST_REAL_BIT  = 4;
    localparam int unsigned ST_SYNC_BIT  = 5;
    localparam int unsigned ST_LINK_BIT  = 6;
    localparam int unsigned PD_A_BIT     = 0;
    localparam int unsigned PD_B_BIT     = 1;
    localparam int unsigned DID_LSB      = 1;

    // reset values
    localparam logic       RST_LINK_EN = 1'b1;
    localparam logic [4:0] RST_MODE    = 5'h02;
    localparam logic [4:0] RST_KM1     = 5'h1F;
    localparam logic       RST_SWSYNC  = 1'b1;
    localparam logic [1:0] RST_SEL     = 2'h0;
    localparam logic       RST_SFMT    = 1'b1;
    localparam logic       RST_SCR     = 1'b0;
    localparam logic [3:0] RST_TEST    = 4'h0;
    localparam logic [6:0] RST_DID_HI  = 7'h00;
    localparam logic [1:0] RST_COMMA   = 2'h0;
    localparam logic [1:0] RST_PD      = 2'h0;
    localparam logic [7:0] RST_EXTRA   = 8'h00;

    // encodings
    localparam logic [1:0] SEL_PIN    = 2'h0;
    localparam logic [1:0] SEL_TIMESTAMP_INPUT_PAIR  = 2'h1;
    localparam logic [1:0] SEL_NONE   = 2'h2;
    localparam logic [3:0] TP_NORMAL  = 4'h0;
    localparam logic [3:0] TP_LAST    = 4'hB;
    localparam logic [1:0] FC_K287    = 2'h0;
    localparam logic [1:0] FC_RSVD    = 2'h3;
    localparam logic [1:0] PD_BOTH    = 2'h3;
endpackage

// ===== verilog/sltcr_sync2.sv
/*
 * Two-flop synchroniser for a bundle of independent level inputs.
 * Assumes each bit is a slow level; bits are not coherent as a word.
 */
`timescale 1ns/1ps
module sltcr_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sltcr_sync_t;

    sltcr_sync_t q;
    sltcr_sync_t d;

    // first stage feeds only the second
    always_comb begin
        d    = q;
        d.s1 = i_d;
        d.s2 = q.s1;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_q = q.s2;
endmodule

// ===== verilog/sltcr_local_multiframe_clock.sv
/*
 * Local multiframe clock counter, one frame per device clock.
 * Assumes i_sysref is a one-cycle pulse already in the clock domain.
 */
`timescale 1ns/1ps
module sltcr_local_multiframe_clock
    import sltcr_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    input  wire logic       i_run,
    input  wire logic [4:0] i_km1,
    input  wire logic       i_sysref,
    output logic            o_local_multiframe_clock_pulse,
    output logic            o_realign
);
    typedef struct packed {
        logic [4:0] cnt;
        logic       pulse;
        logic       realign;
    } sltcr_local_multiframe_clock_t;

    sltcr_local_multiframe_clock_t q;
    sltcr_local_multiframe_clock_t d;
    logic [4:0]  nxt;

    // wrap at K-1; sysref forces phase zero
    always_comb begin
        d         = q;
        d.pulse   = 1'b0;
        d.realign = 1'b0;
        nxt       = (q.cnt == i_km1) ? 5'h00 : q.cnt + 5'h01;
        if (!i_run) begin
            d.cnt = 5'h00;
        end else if (i_sysref) begin
            d.cnt     = 5'h00;
            d.pulse   = 1'b1;
            d.realign = (nxt != 5'h00);
        end else begin
            d.cnt   = nxt;
            d.pulse = (nxt == 5'h00);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_local_multiframe_clock_pulse = q.pulse;
    assign o_realign    = q.realign;

    AST_LOCAL_MULTIFRAME_CLOCK_STOP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !i_run |=> (q.cnt == 5'h00) && !o_local_multiframe_clock_pulse && !o_realign)
        else $error("multiframe counter ran while stopped");
endmodule

// ===== verilog/sltcr_top.sv
/*
 * Control and status register bank of the serial transmit link.
 * Holds link enable, mode, multiframe length, sync request, format,
 * test pattern, identifier, comma, status and power-down settings,
 * and drives the resulting controls to the link logic.
 * Assumes a one-cycle strobe register port on the same clock, and
 * sync pins, SYSREF, PLL lock and link-up arriving asynchronously.
 */
`timescale 1ns/1ps
module sltcr_top
    import sltcr_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_sys_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic              i_sync_pin_n,
    input  wire logic              i_timestamp_input_pair_n,
    input  wire logic              i_timestamp_receiver_enable,
    input  wire logic              i_sysref,
    input  wire logic              i_pll_locked,
    input  wire logic              i_link_up,
    input  wire logic              i_mode_ab_on_link_a,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_link_rst,
    output logic                   o_serializer_pd,
    output logic                   o_link_clk_en,
    output logic      [4:0]        o_output_mode_select,
    output logic      [5:0]        o_k_frames,
    output logic                   o_sync_request,
    output logic                   o_sample_format,
    output logic                   o_scrambler_enable,
    output logic      [3:0]        o_test_pattern_select,
    output logic      [7:0]        o_did_link_a,
    output logic      [7:0]        o_did_link_b,
    output logic      [1:0]        o_eof_comma_select,
    output logic                   o_channel_a_powerdown,
    output logic                   o_channel_b_powerdown,
    output logic                   o_subsystem_powerdown,
    output logic                   o_b_samples_undefined,
    output logic      [7:0]        o_extra_lane_enable_a,
    output logic                   o_local_multiframe_clock_pulse
);
    typedef struct packed {
        // software settings
        logic       link_en;
        logic [4:0] mode;
        logic [4:0] km1;
        logic       sw_sync_n;
        logic [1:0] sync_sel;
        logic       sfmt;
        logic       scrambler_enable;
        logic [3:0] test;
        logic [6:0] did_hi;
        logic [1:0] comma;
        logic [1:0] pd;
        logic [7:0] extra;
        // status state
        logic       realigned;
        logic       multiframe_phase_established;
        logic       first_seen;
        logic       sysref_prev;
        // registered outputs
        logic [7:0] rdata;
        logic       link_rst;
        logic       ser_pd;
        logic       clk_en;
        logic       sync_req;
        logic [5:0] k;
        logic [3:0] tp_eff;
        logic [1:0] comma_eff;
        logic [7:0] did_a;
        logic [7:0] did_b;
        logic       pd_all;
        logic       b_undef;
    } sltcr_regs_t;

    sltcr_regs_t q;
    sltcr_regs_t d;

    // synchronised pin levels
    logic [4:0]  pins_s;
    logic        sync_pin_n_s;
    logic        timestamp_input_pair_n_s;
    logic        sysref_s;
    logic        pll_s;
    logic        link_up_s;

    // decode and live combinational terms
    logic        wr_en_reg;
    logic        wr_status;
    logic        sync_live;
    logic        run;
    logic        sysref_pulse;
    logic        realign_evt;
    logic [7:0]  status;
    logic [7:0]  did_even;
    logic [7:0]  rd_mux;

    // all asynchronous pins pass two flops before any use
    sltcr_sync2 #(
        .W (5)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_d       ({i_link_up, i_pll_locked, i_sysref,
                     i_timestamp_input_pair_n, i_sync_pin_n}),
        .o_q       (pins_s)
    );

    assign sync_pin_n_s = pins_s[0];
    assign timestamp_input_pair_n_s    = pins_s[1];
    assign sysref_s     = pins_s[2];
    assign pll_s        = pins_s[3];
    assign link_up_s    = pins_s[4];

    // counter stops while disabled or the whole subsystem is down
    assign run          = q.link_en && !q.pd_all;
    assign sysref_pulse = sysref_s && !q.sysref_prev && run;

    sltcr_local_multiframe_clock u_local_multiframe_clock (
        .i_clk_sys    (i_clk_sys),
        .i_sys_rst    (i_sys_rst),
        .i_run        (run),
        .i_km1        (q.km1),
        .i_sysref     (sysref_pulse),
        .o_local_multiframe_clock_pulse (o_local_multiframe_clock_pulse),
        .o_realign    (realign_evt)
    );

    // register file, status flags and derived controls
    always_comb begin
        d         = q;
        wr_en_reg = i_wr && (i_addr == A_LINK_EN);
        wr_status = i_wr && (i_addr == A_STATUS);
        did_even  = {q.did_hi, 1'b0};

        // pin term only for the selected source; software always counts
        sync_live = !q.sw_sync_n;
        unique case (q.sync_sel)
            SEL_PIN: begin
                sync_live = sync_live || !sync_pin_n_s;
            end
            SEL_TIMESTAMP_INPUT_PAIR: begin
                sync_live = sync_live || (i_timestamp_receiver_enable && !timestamp_input_pair_n_s);
            end
            default: begin
                sync_live = sync_live;
            end
        endcase

        status                = 8'h00;
        status[ST_LINK_BIT]   = link_up_s;
        status[ST_SYNC_BIT]   = !sync_live;
        status[ST_REAL_BIT]   = q.realigned;
        status[ST_ALIGN_BIT]  = q.multiframe_phase_established;
        status[ST_PLL_BIT]    = pll_s;

        // software writes; reserved bits are not stored
        if (wr_en_reg) begin
            d.link_en = i_wdata[0];
        end
        if (i_wr) begin
            unique case (i_addr)
                A_MODE: begin
                    d.mode = i_wdata[4:0];
                end
                A_KM1: begin
                    d.km1 = i_wdata[4:0];
                end
                A_SWSYNC: begin
                    d.sw_sync_n = i_wdata[0];
                end
                A_CTRL: begin
                    d.sync_sel = i_wdata[CTL_SEL_LSB +: 2];
                    d.sfmt     = i_wdata[CTL_SFMT_BIT];
                    d.scrambler_enable      = i_wdata[CTL_SCR_BIT];
                end
                A_TEST: begin
                    d.test = i_wdata[3:0];
                end
                A_DID: begin
                    d.did_hi = i_wdata[7:DID_LSB];
                end
                A_COMMA: begin
                    d.comma = i_wdata[1:0];
                end
                A_PD: begin
                    d.pd = i_wdata[PD_B_BIT:PD_A_BIT];
                end
                A_EXTRA_A: begin
                    d.extra = i_wdata;
                end
                default: begin
                    d.extra = q.extra;
                end
            endcase
        end

        // sticky flags: a set in the clearing cycle wins
        d.sysref_prev = sysref_s;
        d.realigned   = (q.realigned && !(wr_status && i_wdata[ST_REAL_BIT]))
                        || realign_evt;
        d.multiframe_phase_established     = (q.multiframe_phase_established && !(wr_status && i_wdata[ST_ALIGN_BIT]))
                        || (sysref_pulse && !q.first_seen);
        d.first_seen  = run && (q.first_seen || sysref_pulse);

        // read data stand only in the cycle after the strobe
        unique case (i_addr)
            A_LINK_EN: rd_mux = {7'h00, q.link_en};
            A_MODE:    rd_mux = {3'h0, q.mode};
            A_KM1:     rd_mux = {3'h0, q.km1};
            A_SWSYNC:  rd_mux = {7'h00, q.sw_sync_n};
            A_CTRL:    rd_mux = {4'h0, q.sync_sel, q.sfmt, q.scrambler_enable};
            A_TEST:    rd_mux = {4'h0, q.test};
            A_DID:     rd_mux = did_even;
            A_COMMA:   rd_mux = {6'h00, q.comma};
            A_STATUS:  rd_mux = status;
            A_PD:      rd_mux = {6'h00, q.pd};
            A_EXTRA_A: rd_mux = q.extra;
            default:   rd_mux = 8'h00;
        endcase
        d.rdata = i_rd ? rd_mux : 8'h00;

        // derived link controls, one cycle behind the settings
        d.link_rst  = !q.link_en;
        d.clk_en    = q.link_en;
        d.pd_all    = (q.pd == PD_BOTH);
        d.ser_pd    = !q.link_en || (q.pd == PD_BOTH);
        d.sync_req  = sync_live;
        d.k         = {1'b0, q.km1} + 6'h01;
        // reserved selections fall back to the safe normal codes
        d.tp_eff    = (q.test > TP_LAST) ? TP_NORMAL : q.test;
        d.comma_eff = (q.comma == FC_RSVD) ? FC_K287 : q.comma;
        d.did_a     = did_even;
        d.did_b     = did_even + 8'h01;
        // link A keeps running; B slots carry no valid samples
        d.b_undef   = i_mode_ab_on_link_a && q.pd[PD_B_BIT]
                      && q.link_en && (q.pd != PD_BOTH);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            q            <= '0;
            q.link_en    <= RST_LINK_EN;
            q.mode       <= RST_MODE;
            q.km1        <= RST_KM1;
            q.sw_sync_n  <= RST_SWSYNC;
            q.sync_sel   <= RST_SEL;
            q.sfmt       <= RST_SFMT;
            q.scrambler_enable        <= RST_SCR;
            q.test       <= RST_TEST;
            q.did_hi     <= RST_DID_HI;
            q.comma      <= RST_COMMA;
            q.pd         <= RST_PD;
            q.extra      <= RST_EXTRA;
            q.clk_en     <= RST_LINK_EN;
            q.link_rst   <= !RST_LINK_EN;
            q.ser_pd     <= !RST_LINK_EN;
            q.k          <= {1'b0, RST_KM1} + 6'h01;
            q.did_b      <= {RST_DID_HI, 1'b0} + 8'h01;
        end else begin
            q <= d;
        end
    end

    // every output straight from its flop
    assign o_rdata               = q.rdata;
    assign o_link_rst            = q.link_rst;
    assign o_serializer_pd       = q.ser_pd;
    assign o_link_clk_en         = q.clk_en;
    assign o_output_mode_select  = q.mode;
    assign o_k_frames            = q.k;
    assign o_sync_request        = q.sync_req;
    assign o_sample_format       = q.sfmt;
    assign o_scrambler_enable    = q.scrambler_enable;
    assign o_test_pattern_select = q.tp_eff;
    assign o_did_link_a          = q.did_a;
    assign o_did_link_b          = q.did_b;
    assign o_eof_comma_select    = q.comma_eff;
    assign o_channel_a_powerdown = q.pd[PD_A_BIT];
    assign o_channel_b_powerdown = q.pd[PD_B_BIT];
    assign o_subsystem_powerdown = q.pd_all;
    assign o_b_samples_undefined = q.b_undef;
    assign o_extra_lane_enable_a = q.extra;

    // checks on the register bank
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    AST_LINK_OFF: assert property (
        wr_en_reg && !i_wdata[0] |=> ##1 o_link_rst && o_serializer_pd && !o_link_clk_en)
        else $error("link not held off after disable");

    AST_NO_ALIGN_OFF: assert property (
        !q.link_en && !q.multiframe_phase_established && !(sysref_s && !q.sysref_prev && q.link_en) |=> !q.multiframe_phase_established)
        else $error("alignment flag set while link disabled");

    AST_K_PLUS_ONE: assert property (
        i_wr && (i_addr == A_KM1) |=> ##1 o_k_frames == {1'b0, $past(i_wdata[4:0], 2)} + 6'h01)
        else $error("frames per multiframe not stored value plus one");

    AST_SW_SYNC: assert property (
        i_wr && (i_addr == A_SWSYNC) && !i_wdata[0] |=> ##1 o_sync_request)
        else $error("software sync request not raised");

    AST_SEL_NONE: assert property (
        (q.sync_sel == SEL_NONE) && q.sw_sync_n |=> !o_sync_request)
        else $error("pin request seen with no sync source");

    AST_FORMAT_RST: assert property (
        $fell(i_sys_rst) |-> o_sample_format && !o_scrambler_enable)
        else $error("format or scrambler reset value wrong");

    AST_TP_LEGAL: assert property (
        o_test_pattern_select <= TP_LAST)
        else $error("reserved test pattern reached the link");

    AST_DID_B: assert property (
        o_did_link_b == o_did_link_a + 8'h01)
        else $error("link B identifier not link A plus one");

    AST_DID_EVEN: assert property (
        i_rd && (i_addr == A_DID) |=> !o_rdata[0] && !o_did_link_a[0])
        else $error("identifier bit 0 not zero");

    AST_COMMA_LEGAL: assert property (
        o_eof_comma_select != FC_RSVD)
        else $error("reserved comma select reached the link");

    AST_SYNC_STATUS: assert property (
        i_rd && (i_addr == A_STATUS) |=> o_rdata[ST_SYNC_BIT] == !$past(sync_live))
        else $error("sync status bit not live sync state");

    AST_REALIGN_SET: assert property (
        realign_evt |=> q.realigned)
        else $error("realignment not flagged");

    AST_ALIGN_FIRST: assert property (
        sysref_pulse && !q.first_seen |=> q.multiframe_phase_established ##1 q.first_seen || !q.link_en)
        else $error("first sysref did not set alignment flag");

    AST_PD_ALL: assert property (
        q.pd == PD_BOTH |=> o_subsystem_powerdown ##1 !o_local_multiframe_clock_pulse)
        else $error("both channels down but subsystem running");

    AST_W1C_ZERO: assert property (
        wr_status && !i_wdata[ST_ALIGN_BIT] && q.multiframe_phase_established |=> q.multiframe_phase_established)
        else $error("zero write cleared alignment flag");

    COV_LINK_TOGGLE: cover property (
        !q.link_en ##1 q.link_en ##[1:40] sysref_pulse);
    COV_REALIGN: cover property (realign_evt);
    COV_ALIGN_CLEAR: cover property (q.multiframe_phase_established ##1 wr_status ##1 !q.multiframe_phase_established);
    COV_SW_SYNC: cover property ((q.sync_sel == SEL_NONE) && o_sync_request);
endmodule

// ===== dv/sltcr_rx_model.sv
/*
 * Behavioural far-end receiver: drives the active-low sync line and
 * the SYSREF pulse. Assumes the bench commands it on the device clock.
 */
`timescale 1ns/1ps
module sltcr_rx_model (
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    input  wire logic i_want_sync,
    input  wire logic i_fire,
    output logic      o_sync_n,
    output logic      o_sysref
);
    logic [2:0] cnt_q;
    // sysref held four cycles so a slow synchroniser still sees it
    always_ff @(posedge i_clk_sys) begin
        o_sync_n <= !i_want_sync;
        if (i_sys_rst) cnt_q <= 3'h0;
        else if (i_fire) cnt_q <= 3'h4;
        else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    end
    assign o_sysref = (cnt_q != 3'h0);
endmodule

// ===== dv/sltcr_top_tb_top.sv
/*
 * Self-checking bench for the link control register bank.
 * Assumes sltcr_pkg constants and the one-cycle strobe register port.
 */
`timescale 1ns/1ps
module sltcr_top_tb_top
    import sltcr_pkg::*;
;
    logic i_clk_sys, i_sys_rst, i_wr, i_rd, i_sync_pin_n, i_timestamp_input_pair_n, i_timestamp_receiver_enable;
    logic i_sysref, i_pll_locked, i_link_up, i_mode_ab_on_link_a, want, fire;
    logic o_link_rst, o_serializer_pd, o_link_clk_en, o_sync_request, o_sample_format, o_scrambler_enable;
    logic o_channel_a_powerdown, o_channel_b_powerdown, o_subsystem_powerdown, o_b_samples_undefined, o_local_multiframe_clock_pulse;
    logic [9:0] i_addr;
    logic [7:0] i_wdata, o_rdata, o_did_link_a, o_did_link_b, o_extra_lane_enable_a, rdv;
    logic [4:0] o_output_mode_select;
    logic [5:0] o_k_frames;
    logic [3:0] o_test_pattern_select;
    logic [1:0] o_eof_comma_select;
    int         failures, compares;

    sltcr_top dut (.*);
    sltcr_rx_model rxm (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_want_sync(want), .i_fire(fire),
                        .o_sync_n(i_sync_pin_n), .o_sysref(i_sysref));

    task automatic finish_test();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // settle one or more edges, then sample past the update
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [9:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 rdv = o_rdata;
    endtask

    task automatic t_defaults();
        logic [7:0] dv [12] = '{8'h01, 8'h02, 8'h1F, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 12; i++) begin
            if (i != 8) begin
                rd(A_LINK_EN + 10'(i));
                chk(rdv, dv[i]);
            end
        end
        chk({2'h0, o_k_frames}, 8'h20);
    endtask

    // host clears link enable first, as settings may only change then
    task automatic t_config();
        wr(A_LINK_EN, 8'h00);
        cyc(2);
        chk({5'h0, o_link_rst, o_serializer_pd, o_link_clk_en}, 8'h06);
        wr(A_MODE, 8'hE5);
        rd(A_MODE);
        chk(rdv, 8'h05);
        chk({3'h0, o_output_mode_select}, 8'h05);
        wr(A_KM1, 8'hEF);
        rd(A_KM1);
        chk(rdv, 8'h0F);
        cyc(1);
        chk({2'h0, o_k_frames}, 8'h10);
        wr(A_DID, 8'h2B);
        rd(A_DID);
        chk(rdv, 8'h2A);
        chk(o_did_link_a, 8'h2A);
        chk(o_did_link_b, 8'h2B);
        wr(A_CTRL, 8'h01);
        cyc(2);
        chk({6'h0, o_sample_format, o_scrambler_enable}, 8'h01);
        for (int i = 0; i < 16; i++) begin
            wr(A_TEST, 8'(i));
            cyc(2);
            chk({4'h0, o_test_pattern_select}, (i < 12) ? 8'(i) : 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            wr(A_COMMA, 8'(i));
            cyc(2);
            chk({6'h0, o_eof_comma_select}, (i < 3) ? 8'(i) : 8'h00);
        end
        wr(A_COMMA, 8'h00);
    endtask

    // rows: sw bit, source, pin low, pair low, receiver enable, request
    task automatic t_sync();
        logic [6:0] tv [8] = '{7'b0000000 | 7'h01, 7'b1000000, 7'b1001001, 7'b1101000,
                               7'b0101001, 7'b1010111, 7'b1010100, 7'b1111110};
        for (int i = 0; i < 8; i++) begin
            want                        <= tv[i][3];
            i_timestamp_input_pair_n    <= !tv[i][2];
            i_timestamp_receiver_enable <= tv[i][1];
            wr(A_SWSYNC, {7'h0, tv[i][6]});
            wr(A_CTRL, {4'h0, tv[i][5:4], 2'b10});
            cyc(6);
            chk({7'h0, o_sync_request}, {7'h0, tv[i][0]});
            rd(A_STATUS);
            chk({7'h0, rdv[5]}, {7'h0, !tv[i][0]});
        end
    endtask

    task automatic t_sysref();
        int n;
        i_pll_locked <= 1'b1;
        i_link_up    <= 1'b1;
        fire         <= 1'b1;
        cyc(1);
        fire <= 1'b0;
        cyc(10);
        rd(A_STATUS);
        chk(rdv, 8'h64);
        wr(A_LINK_EN, 8'h01);
        fire <= 1'b1;
        cyc(1);
        fire <= 1'b0;
        cyc(10);
        rd(A_STATUS);
        chk(rdv, 8'h7C);
        wr(A_STATUS, 8'h00);
        rd(A_STATUS);
        chk(rdv, 8'h7C);
        wr(A_STATUS, 8'hFF);
        i_pll_locked <= 1'b0;
        cyc(4);
        rd(A_STATUS);
        chk(rdv, 8'h60);
        n = 0;
        while (o_local_multiframe_clock_pulse !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 200) begin
                failures++;
                finish_test();
            end
        end
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (o_local_multiframe_clock_pulse !== 1'b1 && n < 200);
        chk(8'(n), 8'h10);
    endtask

    task automatic t_power();
        int p;
        wr(A_LINK_EN, 8'h00);
        wr(A_EXTRA_A, 8'h03);
        wr(A_PD, 8'h02);
        wr(A_LINK_EN, 8'h01);
        i_mode_ab_on_link_a <= 1'b1;
        cyc(3);
        chk({4'h0, o_channel_a_powerdown, o_channel_b_powerdown, o_subsystem_powerdown, o_b_samples_undefined},
            8'h05);
        chk(o_extra_lane_enable_a, 8'h03);
        wr(A_LINK_EN, 8'h00);
        wr(A_PD, 8'h03);
        wr(A_LINK_EN, 8'h01);
        cyc(3);
        chk({4'h0, o_channel_a_powerdown, o_channel_b_powerdown, o_subsystem_powerdown, o_serializer_pd},
            8'h0F);
        fire <= 1'b1;
        cyc(1);
        fire <= 1'b0;
        p = 0;
        repeat (40) begin
            cyc(1);
            p += int'(o_local_multiframe_clock_pulse === 1'b1);
        end
        chk(8'(p), 8'h00);
    endtask

    // 40 MHz device clock
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        #2000000;
        failures++;
        finish_test();
    end

    initial begin
        {i_wr, i_rd, i_timestamp_receiver_enable, i_pll_locked, i_link_up, i_mode_ab_on_link_a, want, fire} = '0;
        i_timestamp_input_pair_n = 1'b1;
        i_addr    = A_LINK_EN;
        i_wdata   = 8'h00;
        failures  = 0;
        compares  = 0;
        i_sys_rst = 1'b1;
        repeat (5) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        cyc(4);
        t_defaults();
        t_config();
        t_sync();
        t_sysref();
        t_power();
        finish_test();
    end
endmodule
